/* pmca_array.sv */
// Output and input macrocells with bus load, readback, masks and pin enables
// How it works
// - Sixteen output cells, two routable groups of eight
// - Polarity XOR, then registered or combinational mux
// - Flip-flop acts as D, T, JK or SR
// - Clock from product term or clock pin rise
// - Active-high preset; clear from two terms
// - Native term budget per group; borrow budget per group, split at cell 12 in the second
// - Cell n uses data bit n mod 8
// - Lent terms leave owner; borrow only neighbour
// - Host loads and reads all sixteen cells
// - Bus load beats preset, clear and clock
// - Load on strobe trailing edge or level
// - Two group masks reset to zero
// - Masked cells ignore writes, others load
// - Pin enable is term OR direction bit
// - Output without enable equation drives always
// - Internal node frees pin, keeps feedback
// - 24 input cells: latch, register or pass
// - Host reads input cells over data bus
// - Nibble enable from term or address strobe
// - Address strobe captures port pins in input cells
// - Mailbox: slave read term drives port_a_dout on port A
`timescale 1ns/100ps
`default_nettype none
module pmca_array
  import pmca_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             config_space_sel,
  input  wire logic [7:0]       mcu_addr,
  input  wire logic [7:0]       mcu_data_in,
  input  wire logic             write_strobe_n,
  input  wire logic             read_strobe_n,
  input  wire logic             address_strobe_pin,
  input  wire logic             clock_input_pin,
  input  wire logic             load_level_mode,
  input  wire logic [15:0][3:0] cell_terms,
  input  wire logic [15:0][3:0] cell_lend,
  input  wire logic [15:0]      cell_k_term,
  input  wire logic [15:0]      cell_pol,
  input  wire logic [15:0]      cell_comb,
  input  wire logic [15:0][1:0] cell_ff_type,
  input  wire logic [15:0]      cell_clk_pin_sel,
  input  wire logic [15:0]      cell_pt_clk,
  input  wire logic [15:0]      cell_pt_preset,
  input  wire logic [15:0]      cell_pt_clr_a,
  input  wire logic [15:0]      cell_pt_clr_b,
  input  wire logic [15:0]      cell_pt_oe,
  input  wire logic [15:0]      cell_is_pin,
  input  wire logic [15:0]      cell_oe_defined,
  input  wire logic [15:0]      cell_route_alt,
  input  wire logic [7:0]       dir_a,
  input  wire logic [7:0]       dir_b,
  input  wire logic [7:0]       dir_c,
  input  wire logic [7:0]       port_a_in,
  input  wire logic [7:0]       port_b_in,
  input  wire logic [7:0]       port_c_in,
  input  wire logic [7:0]       port_a_dout,
  input  wire logic             slave_rd_pt,
  input  wire logic [23:0][1:0] imc_mode,
  input  wire logic [5:0]       imc_le_as_sel,
  input  wire logic [5:0]       imc_le_pt,
  output logic      [7:0]       port_a_o,
  output logic      [7:0]       port_a_oe_n,
  output logic      [7:0]       port_b_o,
  output logic      [7:0]       port_b_oe_n,
  output logic      [7:0]       port_c_o,
  output logic      [7:0]       port_c_oe_n,
  output logic      [7:0]       fb_first_output_group,
  output logic      [7:0]       fb_second_output_group,
  output logic      [23:0]      imc_to_array,
  output logic      [7:0]       mcu_data_out,
  output logic                  mcu_data_oe_n
);
  typedef struct packed {
    logic [15:0] q;
    logic [15:0] mux;
    logic [7:0]  mask_first;
    logic [7:0]  mask_second;
    logic        wr_prev;
    logic        wr_hit;
    logic [7:0]  wr_addr;
    logic [7:0]  wr_data;
    logic        clk_pin_prev;
    logic [15:0] pt_clk_prev;
    logic [7:0]  pa_o;
    logic [7:0]  pa_oe_n;
    logic [7:0]  pb_o;
    logic [7:0]  pb_oe_n;
    logic [7:0]  pc_o;
    logic [7:0]  pc_oe_n;
    logic [7:0]  dout;
    logic        dout_oe_n;
  } pmca_state_s;

  pmca_state_s st_q, st_d;

  logic [44:0] pin_raw;
  logic [44:0] pin_f;
  logic [7:0]  s_pa, s_pb, s_pc, s_data, s_addr;
  logic        s_cs, s_clk, s_as, s_rd_n, s_wr_n;
  logic        wr_act, rd_act, go;
  logic [7:0]  eff_addr, eff_data;
  logic [15:0] sum, xr, clr, clk_edge, load_en, ff_next;
  logic [23:0] imc_val;

  assign pin_raw = {port_c_in, port_b_in, port_a_in, mcu_data_in, mcu_addr,
                    config_space_sel, clock_input_pin, address_strobe_pin,
                    read_strobe_n, write_strobe_n};

  pmca_sync #(.W(45)) u_sync (
    .mclk (mclk),
    .rst  (rst),
    .raw  (pin_raw),
    .filt (pin_f)
  );

  assign {s_pc, s_pb, s_pa, s_data, s_addr, s_cs, s_clk, s_as, s_rd_n, s_wr_n} = pin_f;
  assign wr_act = ~s_wr_n;
  assign rd_act = ~s_rd_n;

  // Sum of own unlent native terms plus what the right-hand neighbour lends
  function automatic logic cell_sum(
    input logic [3:0]  nat,
    input logic [3:0]  lent,
    input logic [3:0]  nb_nat,
    input logic [3:0]  nb_lent,
    input int unsigned n_nat,
    input int unsigned cap
  );
    logic        s;
    int unsigned taken;
    s     = 1'b0;
    taken = 0;
    for (int k = 0; k < 4; k++) begin
      if (k < n_nat && !lent[k]) begin
        s = s | nat[k];
      end
    end
    for (int k = 0; k < 4; k++) begin
      if (k < n_nat && nb_lent[k] && taken < cap) begin
        s     = s | nb_nat[k];
        taken = taken + 1;
      end
    end
    return s;
  endfunction : cell_sum

  for (genvar p = 0; p < 3; p++) begin : g_imc
    pmca_imc u_imc (
      .mclk      (mclk),
      .rst       (rst),
      .pins      (p == 0 ? s_pa : (p == 1 ? s_pb : s_pc)),
      .mode      (imc_mode[p*8 +: 8]),
      .le_as_sel (imc_le_as_sel[p*2 +: 2]),
      .le_pt     (imc_le_pt[p*2 +: 2]),
      .as_level  (s_as),
      .val       (imc_val[p*8 +: 8])
    );
  end

  always_comb begin
    st_d = st_q;
    // Level mode takes live values; edge mode uses what stood during the strobe
    if (load_level_mode) begin
      go       = wr_act && s_cs;
      eff_addr = s_addr;
      eff_data = s_data;
    end else begin
      go       = st_q.wr_prev && !wr_act && st_q.wr_hit;
      eff_addr = st_q.wr_addr;
      eff_data = st_q.wr_data;
    end
    st_d.wr_prev = wr_act;
    if (wr_act) begin
      st_d.wr_hit  = s_cs;
      st_d.wr_addr = s_addr;
      st_d.wr_data = s_data;
    end
    if (go && eff_addr == OFS_MASK_FIRST) begin
      st_d.mask_first = eff_data;
    end
    if (go && eff_addr == OFS_MASK_SECOND) begin
      st_d.mask_second = eff_data;
    end

    st_d.clk_pin_prev = s_clk;
    st_d.pt_clk_prev  = cell_pt_clk;
    for (int i = 0; i < CELLS; i++) begin
      sum[i] = cell_sum(cell_terms[i],
                        (i % GRP == 0) ? 4'h0 : cell_lend[i],
                        (i % GRP == GRP - 1) ? 4'h0 : cell_terms[(i + 1) % CELLS],
                        (i % GRP == GRP - 1) ? 4'h0 : cell_lend[(i + 1) % CELLS],
                        (i < GRP) ? NAT_FIRST : NAT_SECOND,
                        (i < GRP) ? BOR_FIRST :
                        ((i < SECOND_HI_AT) ? BOR_SECOND_LO : BOR_SECOND_HI));
      xr[i]  = sum[i] ^ cell_pol[i];
      clr[i] = cell_pt_clr_a[i] | cell_pt_clr_b[i];
      clk_edge[i] = cell_clk_pin_sel[i] ? (s_clk && !st_q.clk_pin_prev)
                                        : (cell_pt_clk[i] && !st_q.pt_clk_prev[i]);
      case (cell_ff_type[i])
        FT_D:    ff_next[i] = xr[i];
        FT_T:    ff_next[i] = st_q.q[i] ^ xr[i];
        FT_JK:   ff_next[i] = (xr[i] & ~st_q.q[i]) | (~cell_k_term[i] & st_q.q[i]);
        FT_SR:   ff_next[i] = xr[i] | (~cell_k_term[i] & st_q.q[i]);
        default: ff_next[i] = st_q.q[i];
      endcase
      if (i < GRP) begin
        load_en[i] = go && eff_addr == OFS_OMC_FIRST && !st_q.mask_first[i % GRP];
      end else begin
        load_en[i] = go && eff_addr == OFS_OMC_SECOND && !st_q.mask_second[i % GRP];
      end
      // A masked cell falls through to its own clear, preset and clock
      if (load_en[i]) begin
        st_d.q[i] = eff_data[i % GRP];
      end else if (clr[i]) begin
        st_d.q[i] = 1'b0;
      end else if (cell_pt_preset[i]) begin
        st_d.q[i] = 1'b1;
      end else if (clk_edge[i]) begin
        st_d.q[i] = ff_next[i];
      end
      st_d.mux[i] = cell_comb[i] ? xr[i] : st_q.q[i];
    end

    // Pin drive; enable low means driving
    for (int b = 0; b < GRP; b++) begin
      if (cell_is_pin[b] && !cell_route_alt[b]) begin
        st_d.pa_o[b]    = st_q.mux[b];
        st_d.pa_oe_n[b] = !(cell_pt_oe[b] || dir_a[b] || !cell_oe_defined[b]);
      end else begin
        st_d.pa_o[b]    = port_a_dout[b];
        st_d.pa_oe_n[b] = !slave_rd_pt;
      end
      if (cell_is_pin[b] && cell_route_alt[b]) begin
        st_d.pb_o[b]    = st_q.mux[b];
        st_d.pb_oe_n[b] = !(cell_pt_oe[b] || dir_b[b] || !cell_oe_defined[b]);
      end else if (cell_is_pin[GRP + b] && !cell_route_alt[GRP + b]) begin
        st_d.pb_o[b]    = st_q.mux[GRP + b];
        st_d.pb_oe_n[b] = !(cell_pt_oe[GRP + b] || dir_b[b] || !cell_oe_defined[GRP + b]);
      end else begin
        st_d.pb_o[b]    = 1'b0;
        st_d.pb_oe_n[b] = 1'b1;
      end
      if (cell_is_pin[GRP + b] && cell_route_alt[GRP + b]) begin
        st_d.pc_o[b]    = st_q.mux[GRP + b];
        st_d.pc_oe_n[b] = !(cell_pt_oe[GRP + b] || dir_c[b] || !cell_oe_defined[GRP + b]);
      end else begin
        st_d.pc_o[b]    = 1'b0;
        st_d.pc_oe_n[b] = 1'b1;
      end
    end

    // Readback; unmapped offsets leave the bus undriven
    st_d.dout_oe_n = 1'b1;
    st_d.dout      = 8'h00;
    if (rd_act && s_cs) begin
      st_d.dout_oe_n = 1'b0;
      case (s_addr)
        OFS_OMC_FIRST:   st_d.dout = st_q.q[7:0];
        OFS_OMC_SECOND:  st_d.dout = st_q.q[15:8];
        OFS_MASK_FIRST:  st_d.dout = st_q.mask_first;
        OFS_MASK_SECOND: st_d.dout = st_q.mask_second;
        OFS_IMC_A:       st_d.dout = imc_val[7:0];
        OFS_IMC_B:       st_d.dout = imc_val[15:8];
        OFS_IMC_C:       st_d.dout = imc_val[23:16];
        default:         st_d.dout_oe_n = 1'b1;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q             <= '0;
      st_q.mask_first  <= MASK_RST;
      st_q.mask_second <= MASK_RST;
      st_q.pa_oe_n     <= 8'hff;
      st_q.pb_oe_n     <= 8'hff;
      st_q.pc_oe_n     <= 8'hff;
      st_q.dout_oe_n   <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign port_a_o               = st_q.pa_o;
  assign port_a_oe_n            = st_q.pa_oe_n;
  assign port_b_o               = st_q.pb_o;
  assign port_b_oe_n            = st_q.pb_oe_n;
  assign port_c_o               = st_q.pc_o;
  assign port_c_oe_n            = st_q.pc_oe_n;
  assign fb_first_output_group  = st_q.mux[7:0];
  assign fb_second_output_group = st_q.mux[15:8];
  assign imc_to_array           = imc_val;
  assign mcu_data_out           = st_q.dout;
  assign mcu_data_oe_n          = st_q.dout_oe_n;

  property p_mask_reset;
    @(posedge mclk) rst |=> (st_q.mask_first == 8'h00 && st_q.mask_second == 8'h00);
  endproperty
  a_mask_reset: assert property (p_mask_reset) else $error("mask not cleared by reset");

  property p_masked_ignored;
    @(posedge mclk) disable iff (rst)
      (go && eff_addr == OFS_OMC_FIRST && st_q.mask_first[3] && !st_q.mask_first[4] && !clr[3]
       && !cell_pt_preset[3] && !clk_edge[3])
      |=> (st_q.q[3] == $past(st_q.q[3]) && st_q.q[4] == $past(eff_data[4]));
  endproperty
  a_masked_ignored: assert property (p_masked_ignored) else $error("masked cell loaded");

  property p_load_beats_clear;
    @(posedge mclk) disable iff (rst)
      (load_en[0] && clr[0]) |=> (st_q.q[0] == $past(eff_data[0]));
  endproperty
  a_load_beats_clear: assert property (p_load_beats_clear) else $error("clear won over load");

  property p_clear;
    @(posedge mclk) disable iff (rst)
      (!load_en[9] && clr[9]) |=> (st_q.q[9] == 1'b0);
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not reset cell");

  property p_masked_keeps_logic;
    @(posedge mclk) disable iff (rst)
      (st_q.mask_first[2] && go && !clr[2] && !cell_pt_preset[2] && !clk_edge[2]) |=> $stable(st_q.q[2]);
  endproperty
  a_masked_keeps_logic: assert property (p_masked_keeps_logic) else $error("masked cell disturbed");

  property p_comb_path;
    @(posedge mclk) disable iff (rst)
      cell_comb[4] |=> (st_q.mux[4] == $past(xr[4]));
  endproperty
  a_comb_path: assert property (p_comb_path) else $error("combinational path wrong");

  property p_readback;
    @(posedge mclk) disable iff (rst)
      (rd_act && s_cs && s_addr == OFS_OMC_SECOND) |=> (!mcu_data_oe_n && mcu_data_out == $past(st_q.q[15:8]));
  endproperty
  a_readback: assert property (p_readback) else $error("readback mismatch");

  property p_edge_load;
    @(posedge mclk) disable iff (rst)
      (!load_level_mode && st_q.wr_prev && !wr_act && st_q.wr_hit && st_q.wr_addr == OFS_OMC_FIRST
       && st_q.mask_first == 8'h00) |=> (st_q.q[7:0] == $past(st_q.wr_data));
  endproperty
  a_edge_load: assert property (p_edge_load) else $error("trailing edge load missed");

  property p_pin_enable;
    @(posedge mclk) disable iff (rst)
      (cell_is_pin[1] && !cell_route_alt[1] && cell_pt_oe[1]) |=> !port_a_oe_n[1];
  endproperty
  a_pin_enable: assert property (p_pin_enable) else $error("pin driver not enabled");
endmodule : pmca_array
`default_nettype wire

/* pmca_pkg.sv */
// Shared constants for the macrocell array: offsets, budgets and encodings
`default_nettype none
package pmca_pkg;
  localparam int unsigned CELLS = 16;
  localparam int unsigned GRP   = 8;

  // Register offsets inside the configuration register space
  localparam logic [7:0] OFS_OMC_FIRST   = 8'h20;
  localparam logic [7:0] OFS_OMC_SECOND  = 8'h21;
  localparam logic [7:0] OFS_MASK_FIRST  = 8'h22;
  localparam logic [7:0] OFS_MASK_SECOND = 8'h23;
  localparam logic [7:0] OFS_IMC_A       = 8'h0a;
  localparam logic [7:0] OFS_IMC_B       = 8'h0b;
  localparam logic [7:0] OFS_IMC_C       = 8'h18;
  localparam logic [7:0] MASK_RST        = 8'h00;

  // Product term budget per cell
  localparam int unsigned NAT_FIRST     = 3;
  localparam int unsigned BOR_FIRST     = 6;
  localparam int unsigned NAT_SECOND    = 4;
  localparam int unsigned BOR_SECOND_LO = 5;
  localparam int unsigned BOR_SECOND_HI = 6;
  localparam int unsigned SECOND_HI_AT  = 12;

  // Flip-flop behaviour
  localparam logic [1:0] FT_D  = 2'h0;
  localparam logic [1:0] FT_T  = 2'h1;
  localparam logic [1:0] FT_JK = 2'h2;
  localparam logic [1:0] FT_SR = 2'h3;

  // Input cell modes
  localparam logic [1:0] IMC_PASS  = 2'h0;
  localparam logic [1:0] IMC_LATCH = 2'h1;
  localparam logic [1:0] IMC_REG   = 2'h2;
endpackage : pmca_pkg
`default_nettype wire

/* pmca_sync.sv */
// Three-stage pin synchroniser with second/third stage agreement
`timescale 1ns/100ps
`default_nettype none
module pmca_sync #(
  parameter int unsigned W = 8
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic [W-1:0] raw,
  output logic      [W-1:0] filt
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] f;
  } pmca_sync_s;

  pmca_sync_s st_q, st_d;

  always_comb begin
    st_d    = st_q;
    st_d.s1 = raw;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    // A bit moves only once the two later stages agree
    st_d.f  = (st_q.s2 & ~(st_q.s2 ^ st_q.s3)) | (st_q.f & (st_q.s2 ^ st_q.s3));
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign filt = st_q.f;
endmodule : pmca_sync
`default_nettype wire

/* pmca_imc.sv */
// Eight input cells of one port: pass, transparent latch or edge register
`timescale 1ns/100ps
`default_nettype none
module pmca_imc
  import pmca_pkg::*;
(
  input  wire logic            mclk,
  input  wire logic            rst,
  input  wire logic [7:0]      pins,
  input  wire logic [7:0][1:0] mode,
  input  wire logic [1:0]      le_as_sel,
  input  wire logic [1:0]      le_pt,
  input  wire logic            as_level,
  output logic      [7:0]      val
);
  typedef struct packed {
    logic [7:0] val;
    logic [1:0] en_prev;
  } pmca_imc_s;

  pmca_imc_s  st_q, st_d;
  logic [1:0] en;

  always_comb begin
    st_d = st_q;
    for (int n = 0; n < 2; n++) begin
      en[n] = le_as_sel[n] ? as_level : le_pt[n];
    end
    st_d.en_prev = en;
    for (int b = 0; b < 8; b++) begin
      case (mode[b])
        IMC_PASS:  st_d.val[b] = pins[b];
        IMC_LATCH: st_d.val[b] = en[b/4] ? pins[b] : st_q.val[b];
        IMC_REG:   st_d.val[b] = (en[b/4] && !st_q.en_prev[b/4]) ? pins[b] : st_q.val[b];
        default:   st_d.val[b] = st_q.val[b];
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign val = st_q.val;

  property p_imc_pass;
    @(posedge mclk) disable iff (rst)
      (mode[0] == IMC_PASS) |=> (val[0] == $past(pins[0]));
  endproperty
  a_imc_pass: assert property (p_imc_pass) else $error("pass cell did not follow pin");

  property p_imc_latch_hold;
    @(posedge mclk) disable iff (rst)
      (mode[5] == IMC_LATCH && !en[1]) |=> $stable(val[5]);
  endproperty
  a_imc_latch_hold: assert property (p_imc_latch_hold) else $error("closed latch changed");
endmodule : pmca_imc
`default_nettype wire

/* pmca_mcu_model.sv */
// Host processor model driving the configuration register space strobes
`timescale 1ns/100ps
`default_nettype none
module pmca_mcu_model (
  input  wire logic       mclk,
  input  wire logic [7:0] mcu_data_out,
  input  wire logic       mcu_data_oe_n,
  output logic            config_space_sel,
  output logic      [7:0] mcu_addr,
  output logic      [7:0] mcu_data_in,
  output logic            write_strobe_n,
  output logic            read_strobe_n
);
  initial begin
    config_space_sel = 1'b0;
    mcu_addr         = 8'h00;
    mcu_data_in      = 8'h00;
    write_strobe_n   = 1'b1;
    read_strobe_n    = 1'b1;
  end

  // Released lines flip so a stale value never looks valid
  task automatic release_bus;
    @(posedge mclk);
    config_space_sel <= 1'b0;
    mcu_addr         <= ~mcu_addr;
    mcu_data_in      <= ~mcu_data_in;
  endtask : release_bus

  task automatic bus_write(input logic [7:0] addr, input logic [7:0] data);
    @(posedge mclk);
    config_space_sel <= 1'b1;
    mcu_addr         <= addr;
    mcu_data_in      <= data;
    write_strobe_n   <= 1'b0;
    repeat (6) @(posedge mclk);
    write_strobe_n <= 1'b1;
    // Address and data held past the filtered strobe release
    repeat (8) @(posedge mclk);
    release_bus();
  endtask : bus_write

  task automatic bus_read(input logic [7:0] addr, output logic [7:0] data, output logic hit);
    hit  = 1'b0;
    data = 8'h00;
    @(posedge mclk);
    config_space_sel <= 1'b1;
    mcu_addr         <= addr;
    read_strobe_n    <= 1'b0;
    // Answer taken at the rising edge that sees it, strobe let go at that edge
    for (int n = 0; n < 16 && !hit; n++) begin
      @(posedge mclk);
      if (mcu_data_oe_n === 1'b0) begin
        hit  = 1'b1;
        data = mcu_data_out;
      end
    end
    read_strobe_n <= 1'b1;
    repeat (8) @(posedge mclk);
    release_bus();
  endtask : bus_read
endmodule : pmca_mcu_model
`default_nettype wire

/* pmca_array_tb_top.sv */
// Self-checking bench for the macrocell array through its host bus
`timescale 1ns/100ps
`default_nettype none
module pmca_array_tb_top
  import pmca_pkg::*;
;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic sel, wr_n, rd_n, as_pin = 1'b0, ck_pin = 1'b0, lvl = 1'b0, srd = 1'b0, oe_n;
  logic [7:0] addr, din, dout, pa_dout = 8'h00, pa_in = 8'h00, pb_in = 8'h00, pc_in = 8'h00;
  logic [7:0] dir_a = 8'h00, dir_b = 8'h00, dir_c = 8'h00;
  logic [7:0] pa_o, pa_oe_n, fb_a;
  logic [7:0] pb_o, pb_oe_n, pc_o, pc_oe_n, fb_b;
  logic [15:0][3:0] terms = '0, lend = '0;
  logic [15:0][1:0] fft = '0;
  logic [15:0] kt = '0, pol = '0, comb = '0, cps = '0, pclk = '0, pre = '0;
  logic [15:0] clra = '0, clrb = '0, poe = '0, is_pin = '0, oe_def = '0, ralt = '0;
  logic [23:0][1:0] imode = '0;
  logic [5:0] le_as = '0, le_pt = '0;
  logic [23:0] imc_arr;
  int miscompares = 0;
  int checks_done = 0;

  always #25 mclk = ~mclk;

  pmca_mcu_model MCU (.mclk(mclk), .mcu_data_out(dout), .mcu_data_oe_n(oe_n), .config_space_sel(sel),
    .mcu_addr(addr), .mcu_data_in(din), .write_strobe_n(wr_n), .read_strobe_n(rd_n));

  pmca_array DUT (.mclk(mclk), .rst(rst), .config_space_sel(sel), .mcu_addr(addr), .mcu_data_in(din),
    .write_strobe_n(wr_n), .read_strobe_n(rd_n), .address_strobe_pin(as_pin), .clock_input_pin(ck_pin),
    .load_level_mode(lvl), .cell_terms(terms), .cell_lend(lend), .cell_k_term(kt), .cell_pol(pol),
    .cell_comb(comb), .cell_ff_type(fft), .cell_clk_pin_sel(cps), .cell_pt_clk(pclk),
    .cell_pt_preset(pre), .cell_pt_clr_a(clra), .cell_pt_clr_b(clrb), .cell_pt_oe(poe),
    .cell_is_pin(is_pin), .cell_oe_defined(oe_def), .cell_route_alt(ralt), .dir_a(dir_a),
    .dir_b(dir_b), .dir_c(dir_c), .port_a_in(pa_in), .port_b_in(pb_in), .port_c_in(pc_in),
    .port_a_dout(pa_dout), .slave_rd_pt(srd), .imc_mode(imode), .imc_le_as_sel(le_as),
    .imc_le_pt(le_pt), .port_a_o(pa_o), .port_a_oe_n(pa_oe_n), .port_b_o(pb_o), .port_b_oe_n(pb_oe_n),
    .port_c_o(pc_o), .port_c_oe_n(pc_oe_n), .fb_first_output_group(fb_a), .fb_second_output_group(fb_b),
    .imc_to_array(imc_arr), .mcu_data_out(dout), .mcu_data_oe_n(oe_n));

  task automatic end_of_test;
    $display("Checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic rd_check(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       hit;
    MCU.bus_read(a, d, hit);
    if (!hit) begin
      miscompares++;
      $display("Error %s expected answer seen none", what);
      end_of_test();
    end else begin
      check(what, exp, d);
    end
  endtask : rd_check

  initial begin
    logic [7:0] d;
    logic       hit;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    repeat (6) @(posedge mclk);
    rd_check("mask first", OFS_MASK_FIRST, MASK_RST);
    rd_check("mask second", OFS_MASK_SECOND, MASK_RST);
    rd_check("cells first", OFS_OMC_FIRST, 8'h00);
    MCU.bus_write(OFS_OMC_FIRST, 8'ha5);
    MCU.bus_write(OFS_OMC_SECOND, 8'h3c);
    rd_check("cells first", OFS_OMC_FIRST, 8'ha5);
    rd_check("cells second", OFS_OMC_SECOND, 8'h3c);
    // Masked cells must keep their own value, others load
    MCU.bus_write(OFS_MASK_FIRST, 8'h0f);
    MCU.bus_write(OFS_MASK_SECOND, 8'hf0);
    rd_check("mask first", OFS_MASK_FIRST, 8'h0f);
    MCU.bus_write(OFS_OMC_FIRST, 8'hff);
    MCU.bus_write(OFS_OMC_SECOND, 8'h00);
    rd_check("masked first", OFS_OMC_FIRST, 8'hf5);
    rd_check("masked second", OFS_OMC_SECOND, 8'h30);
    @(posedge mclk);
    lvl <= 1'b1;
    MCU.bus_write(OFS_MASK_FIRST, 8'h00);
    MCU.bus_write(OFS_OMC_FIRST, 8'h5a);
    rd_check("level load", OFS_OMC_FIRST, 8'h5a);
    @(posedge mclk);
    pre <= 16'h0201;
    repeat (4) @(posedge mclk);
    rd_check("preset", OFS_OMC_FIRST, 8'h5b);
    rd_check("preset second", OFS_OMC_SECOND, 8'h32);
    @(posedge mclk);
    clrb[0] <= 1'b1;
    clra[9] <= 1'b1;
    repeat (4) @(posedge mclk);
    rd_check("clear over preset", OFS_OMC_FIRST, 8'h5a);
    rd_check("clear second", OFS_OMC_SECOND, 8'h30);
    // Load wins while clear stands, then clear takes the cell back
    MCU.bus_write(OFS_OMC_FIRST, 8'h3b);
    rd_check("load over clear", OFS_OMC_FIRST, 8'h3a);
    @(posedge mclk);
    pre      <= '0;
    clrb     <= '0;
    clra     <= '0;
    is_pin   <= 16'h300e;
    ralt     <= 16'h1000;
    oe_def   <= 16'h0006;
    comb[4]  <= 1'b1;
    poe[1]   <= 1'b1;
    dir_a[2] <= 1'b1;
    repeat (4) @(negedge mclk);
    check("pin enables a", 8'hf1, pa_oe_n);
    check("pin enables b", 8'hdf, pb_oe_n);
    check("pin enables c", 8'hef, pc_oe_n);
    check("pin data a", {6'h0, 2'b10}, {6'h0, pa_o[1], pa_o[0]});
    check("pin data bc", 8'h30, pb_o | pc_o);
    check("feedback a", 8'h2a, fb_a);
    check("feedback b", 8'h30, fb_b);
    @(posedge mclk);
    srd     <= 1'b1;
    pa_dout <= 8'h97;
    repeat (4) @(negedge mclk);
    check("mailbox pin", 8'h01, {6'h0, pa_oe_n[0], pa_o[0]});
    @(posedge mclk);
    pa_in <= 8'h3c;
    pc_in <= 8'hc3;
    repeat (8) @(posedge mclk);
    rd_check("inputs a", OFS_IMC_A, 8'h3c);
    rd_check("inputs c", OFS_IMC_C, 8'hc3);
    check("inputs to array", 8'h3c, imc_arr[7:0]);
    @(posedge mclk);
    for (int i = 8; i < 16; i++) begin
      imode[i] <= IMC_REG;
    end
    le_as     <= 6'h0c;
    pb_in     <= 8'h81;
    imode[21] <= IMC_LATCH;
    pc_in     <= 8'hff;
    cps[13]   <= 1'b1;
    fft[13]   <= FT_T;
    pol[13]   <= 1'b1;
    repeat (6) @(posedge mclk);
    as_pin <= 1'b1;
    ck_pin <= 1'b1;
    repeat (6) @(posedge mclk);
    as_pin <= 1'b0;
    ck_pin <= 1'b0;
    pb_in  <= 8'h00;
    repeat (6) @(posedge mclk);
    rd_check("strobe capture b", OFS_IMC_B, 8'h81);
    rd_check("latch closed c", OFS_IMC_C, 8'hdf);
    rd_check("clock pin toggle", OFS_OMC_SECOND, 8'h10);
    @(posedge mclk);
    le_pt[5] <= 1'b1;
    repeat (2) @(posedge mclk);
    rd_check("latch open c", OFS_IMC_C, 8'hff);
    MCU.bus_read(8'h55, d, hit);
    check("unmapped answer", 8'h00, {7'h0, hit});
    end_of_test();
  end
endmodule : pmca_array_tb_top
`default_nettype wire
